//--- src/rcip_top.sv
// sixteen-channel relay i/o block with standard and pwm drive, ahb-lite slave
//
// Notes on behaviour
// - sixteen channels, each with driver and monitor
// - drivers are active low, open collector
// - indicator lit whenever physical state active
// - drive state read back; debounced state readable
// - pwm waveform runs with no client traffic
// - standard or pwm mode, independent per channel
// - standard driver holds last programmed state
// - pwm alternates active and inactive as configured
// - sample every 10 ms, 10 ms debounce
// - physical-state reads return only the debounced image; drive, mode and pwm reads return those registers
// - modes are a 16-bit word, one=pwm
// - reset gives standard mode, drivers inactive
// - into pwm clears ratio; into standard clears driver
// - on/off bytes in 2 ms; off zero becomes one
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module rcip_top
  import rcip_pkg::*;
#(
  parameter int unsigned NCH        = NUM_CH,
  parameter int unsigned UNIT_CYC   = PWM_UNIT_CYC,
  parameter int unsigned SAMPLE_CYC_P = SAMPLE_CYC
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic            hready,
  input  wire logic [31:0]     hwdata,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // relay channels
  input  wire logic [NCH-1:0]  chan_monitor,
  output logic [NCH-1:0]       drive_out_n,
  output logic [NCH-1:0]       drive_oe_n,
  output logic [NCH-1:0]       indicator
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [NCH-1:0]        drive_reg;
  logic [NCH-1:0]        mode_reg;
  logic [CH_IDX_W-1:0]   pwm_sel_reg;
  rcip_pwm_cfg_t         cfg_reg [NCH];
  rcip_bus_req_t         req_reg;
  logic [NCH-1:0]        mon_meta_reg;
  logic [NCH-1:0]        mon_sync_reg;
  logic [NCH-1:0]        sample_reg;
  logic [NCH-1:0]        debounced_reg;
  logic [3:0]            agree_cnt_reg [NCH];
  logic [NCH-1:0]        pwm_wave;
  logic [NCH-1:0]        drive_eff;
  logic                  unit_tick;
  logic                  sample_tick;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] off_clamp(input logic [7:0] v);
    return (v == 8'h00) ? OFF_MIN : v;
  endfunction

  function automatic logic [31:0] zext16(input logic [NCH-1:0] v);
    logic [31:0] r;
    r = '0;
    r[NCH-1:0] = v;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // tick prescaler

  rcip_tick_gen #(
    .UNIT_CYC     (UNIT_CYC),
    .SAMPLE_CYC_P (SAMPLE_CYC_P)
  ) u_ticks (
    .clk         (clk),
    .rst         (rst),
    .unit_tick   (unit_tick),
    .sample_tick (sample_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  logic addr_ok;
  logic wr_phase;
  assign addr_ok  = hsel && hready &&
                    (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_phase = req_reg.sel && req_reg.write;

  always_ff @(posedge clk) begin
    if (rst) begin
      req_reg <= '0;
    end else if (hready) begin
      req_reg.sel   <= addr_ok;
      req_reg.write <= hwrite;
      req_reg.addr  <= haddr[7:0];
    end
  end

  // zero wait states; every response is okay
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register and standard drive state

  logic [NCH-1:0] mode_wdata;
  logic           mode_wr;
  logic           drive_wr;
  assign mode_wr    = wr_phase && (req_reg.addr == OFS_MODE);
  assign drive_wr   = wr_phase && (req_reg.addr == OFS_DRIVE);
  assign mode_wdata = hwdata[NCH-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= MODE_RST;
    end else if (mode_wr) begin
      mode_reg <= mode_wdata;
    end
  end

  // pwm channels ignore drive writes; a channel entering standard mode is
  // forced inactive so it cannot jump on before being commanded
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_reg <= DRIVE_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (mode_wr && !mode_wdata[i] && mode_reg[i]) begin
          drive_reg[i] <= 1'b0;
        end else if (drive_wr && !mode_reg[i]) begin
          drive_reg[i] <= hwdata[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm timing configuration

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_sel_reg <= '0;
    end else if (wr_phase && req_reg.addr == OFS_PWM_SEL) begin
      pwm_sel_reg <= hwdata[CH_IDX_W-1:0];
    end
  end

  // times are only accepted for a channel already in pwm mode
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= '{off_time: OFF_RST, on_time: ON_RST};
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (mode_wr && mode_wdata[i] && !mode_reg[i]) begin
          cfg_reg[i] <= '{off_time: OFF_RST, on_time: ON_RST};
        end else if (wr_phase && req_reg.addr == OFS_PWM_TIME &&
                     pwm_sel_reg == CH_IDX_W'(i) && mode_reg[i]) begin
          cfg_reg[i].on_time  <= hwdata[ON_LSB +: 8];
          cfg_reg[i].off_time <= off_clamp(hwdata[OFF_LSB +: 8]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel waveform generators

  for (genvar g = 0; g < NCH; g++) begin : g_pwm
    rcip_pwm_chan u_pwm (
      .clk       (clk),
      .rst       (rst),
      .enable    (mode_reg[g]),
      .unit_tick (unit_tick),
      .cfg       (cfg_reg[g]),
      .wave      (pwm_wave[g])
    );
  end

  assign drive_eff = (mode_reg & pwm_wave) | (~mode_reg & drive_reg);

  // all channels update on the same edge; released pin reads high
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_out_n <= '0;
      drive_oe_n  <= '1;
    end else begin
      drive_out_n <= '0;
      drive_oe_n  <= ~drive_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor sampling and debounce

  // monitor pin is high when the channel is active
  always_ff @(posedge clk) begin
    if (rst) begin
      mon_meta_reg <= '0;
      mon_sync_reg <= '0;
    end else begin
      mon_meta_reg <= chan_monitor;
      mon_sync_reg <= mon_meta_reg;
    end
  end

  // indicator follows the physical state, whoever makes it active
  always_ff @(posedge clk) begin
    if (rst) begin
      indicator <= '0;
    end else begin
      indicator <= mon_sync_reg;
    end
  end

  // a new level must hold for the debounce span of samples before it is
  // taken, which trades response time for immunity to contact bounce
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_reg    <= '0;
      debounced_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        agree_cnt_reg[i] <= '0;
      end
    end else if (sample_tick) begin
      sample_reg <= mon_sync_reg;
      for (int i = 0; i < NCH; i++) begin
        if (mon_sync_reg[i] == debounced_reg[i] ||
            mon_sync_reg[i] != sample_reg[i]) begin
          agree_cnt_reg[i] <= '0;
        end else if (agree_cnt_reg[i] >= 4'(DEB_SAMPLES - 1)) begin
          debounced_reg[i] <= mon_sync_reg[i];
          agree_cnt_reg[i] <= '0;
        end else begin
          agree_cnt_reg[i] <= agree_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (addr_ok && !hwrite) begin
      if (haddr[7:0] == OFS_DRIVE) begin
        hrdata <= zext16(drive_reg);
      end else if (haddr[7:0] == OFS_PHYS) begin
        hrdata <= zext16(debounced_reg);
      end else if (haddr[7:0] == OFS_MODE) begin
        hrdata <= zext16(mode_reg);
      end else if (haddr[7:0] == OFS_PWM_SEL) begin
        hrdata <= {28'h0000000, pwm_sel_reg};
      end else if (haddr[7:0] == OFS_PWM_TIME) begin
        hrdata <= {16'h0000, cfg_reg[pwm_sel_reg].off_time,
                   cfg_reg[pwm_sel_reg].on_time};
      end else begin
        hrdata <= '0;
      end
    end else begin
      hrdata <= '0;
    end
  end

  // input-relay channels depend on the client leaving drive_reg low
endmodule // rcip_top

//--- src/rcip_pkg.sv
// shared constants, register map and carrier types for the relay channel block
package rcip_pkg;
  localparam int unsigned NUM_CH          = 16;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned PWM_UNIT_MS     = 2;
  localparam int unsigned SAMPLE_MS       = 10;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned PWM_UNIT_CYC    = CLK_HZ / 1000 * PWM_UNIT_MS;
  localparam int unsigned SAMPLE_CYC      = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned DEB_SAMPLES     = DEBOUNCE_MS / SAMPLE_MS;
  localparam int unsigned PRESC_W         = 20;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_DRIVE        = 8'h00;
  localparam logic [7:0] OFS_PHYS         = 8'h04;
  localparam logic [7:0] OFS_MODE         = 8'h08;
  localparam logic [7:0] OFS_PWM_SEL      = 8'h0c;
  localparam logic [7:0] OFS_PWM_TIME     = 8'h10;

  localparam logic [15:0] DRIVE_RST       = 16'h0000;
  localparam logic [15:0] MODE_RST        = 16'h0000;
  localparam logic [7:0]  ON_RST          = 8'h00;
  localparam logic [7:0]  OFF_RST         = 8'h01;
  localparam logic [7:0]  OFF_MIN         = 8'h01;
  localparam int unsigned ON_LSB          = 0;
  localparam int unsigned OFF_LSB         = 8;
  localparam int unsigned CH_IDX_W        = 4;

  localparam logic [1:0] HTRANS_NONSEQ    = 2'b10;
  localparam logic [1:0] HTRANS_SEQ       = 2'b11;

  typedef struct packed {
    logic [7:0] off_time;
    logic [7:0] on_time;
  } rcip_pwm_cfg_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } rcip_bus_req_t;

  typedef enum logic [1:0] {
    PWM_IDLE = 2'b00,
    PWM_ON   = 2'b01,
    PWM_OFF  = 2'b10
  } rcip_pwm_state_t;
endpackage

//--- src/rcip_tick_gen.sv
// prescaler that turns the system clock into the shared time-unit and sample ticks
`timescale 1ns/100ps
module rcip_tick_gen
  import rcip_pkg::*;
#(
  parameter int unsigned UNIT_CYC   = PWM_UNIT_CYC,
  parameter int unsigned SAMPLE_CYC_P = SAMPLE_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // ticks, one cycle wide
  output logic      unit_tick,
  output logic      sample_tick
);
  logic [PRESC_W-1:0] unit_cnt_reg;
  logic [PRESC_W-1:0] samp_cnt_reg;

  // both counters free-run so every channel shares the same tick edges
  always_ff @(posedge clk) begin
    if (rst) begin
      unit_cnt_reg <= '0;
      unit_tick    <= 1'b0;
    end else if (unit_cnt_reg == PRESC_W'(UNIT_CYC - 1)) begin
      unit_cnt_reg <= '0;
      unit_tick    <= 1'b1;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + 1'b1;
      unit_tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_cnt_reg <= '0;
      sample_tick  <= 1'b0;
    end else if (samp_cnt_reg == PRESC_W'(SAMPLE_CYC_P - 1)) begin
      samp_cnt_reg <= '0;
      sample_tick  <= 1'b1;
    end else begin
      samp_cnt_reg <= samp_cnt_reg + 1'b1;
      sample_tick  <= 1'b0;
    end
  end
endmodule // rcip_tick_gen

//--- src/rcip_pwm_chan.sv
// one channel's autonomous on/off waveform generator
`timescale 1ns/100ps
module rcip_pwm_chan
  import rcip_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // control
  input  wire logic          enable,
  input  wire logic          unit_tick,
  input  wire rcip_pwm_cfg_t cfg,
  // waveform, high while active
  output logic               wave
);
  rcip_pwm_state_t state_reg;
  logic [7:0]      cnt_reg;
  logic [7:0]      off_reg;

  // new times are latched only at a phase boundary, so the running phase
  // finishes with its old length
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      state_reg <= PWM_IDLE;
      cnt_reg   <= 8'h00;
      off_reg   <= OFF_RST;
      wave      <= 1'b0;
    end else if (unit_tick) begin
      case (state_reg)
        PWM_IDLE, PWM_OFF: begin
          if (state_reg == PWM_OFF && cnt_reg != 8'h01) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (cfg.on_time != 8'h00) begin
            state_reg <= PWM_ON;
            cnt_reg   <= cfg.on_time;
            off_reg   <= cfg.off_time;
            wave      <= 1'b1;
          end else begin
            state_reg <= PWM_OFF;
            cnt_reg   <= cfg.off_time;
            off_reg   <= cfg.off_time;
            wave      <= 1'b0;
          end
        end
        PWM_ON: begin
          if (cnt_reg != 8'h01) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            state_reg <= PWM_OFF;
            cnt_reg   <= off_reg;
            wave      <= 1'b0;
          end
        end
        default: begin
          state_reg <= PWM_IDLE;
          wave      <= 1'b0;
        end
      endcase
    end
  end
endmodule // rcip_pwm_chan

//--- verif/rcip_top_sva.sv
// port-level assertions for the relay channel block
`timescale 1ns/100ps
module rcip_top_sva
  import rcip_pkg::*;
#(
  parameter int unsigned NCH = NUM_CH
) (
  // clock and reset
  input wire logic           clk,
  input wire logic           rst,
  // bus
  input wire logic           hsel,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic           hready,
  input wire logic [31:0]    hwdata,
  input wire logic [31:0]    hrdata,
  input wire logic           hreadyout,
  input wire logic           hresp,
  // channels
  input wire logic [NCH-1:0] chan_monitor,
  input wire logic [NCH-1:0] drive_out_n,
  input wire logic [NCH-1:0] drive_oe_n,
  input wire logic [NCH-1:0] indicator
);
  logic           dph;
  logic           dwr;
  logic [7:0]     dadr;
  logic [NCH-1:0] mode_q;
  logic           drv_wr;
  logic           mode_wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  // data phase tracker and a shadow of the mode word
  always_ff @(posedge clk) begin
    if (rst) begin
      dph <= 1'b0;
    end else begin
      dph <= hsel && hready && htrans[1];
    end
  end

  always_ff @(posedge clk) begin
    dwr  <= hwrite;
    dadr <= haddr[7:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= '0;
    end else if (mode_wr) begin
      mode_q <= hwdata[NCH-1:0];
    end
  end

  assign drv_wr  = dph && dwr && dadr == OFS_DRIVE;
  assign mode_wr = dph && dwr && dadr == OFS_MODE;

  ////////////////////////////////////////
  a_oe_reset: assert property ($fell(rst) |-> drive_oe_n == '1 && hrdata == 32'h0)
    else $error("drivers or read data not idle after reset");
  a_drv_low: assert property (drive_out_n == '0)
    else $error("driver value not low");
  a_ind_track: assert property ((!rst && $stable(chan_monitor))[*4] |-> indicator == chan_monitor)
    else $error("indicator does not follow channel state");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_rd_idle: assert property (!dph |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_rd_mode: assert property (dph && !dwr && dadr == OFS_MODE
    |-> hrdata == {{(32-NCH){1'b0}}, mode_q})
    else $error("mode word read back wrong");
  a_std_drive: assert property (drv_wr && mode_q == '0
    |=> ##1 drive_oe_n == ~$past(hwdata[NCH-1:0], 2))
    else $error("standard drive not applied on one edge");
  a_std_hold: assert property (!drv_wr && !$past(drv_wr) && mode_q == '0
    && $past(mode_q) == '0 |=> $stable(drive_oe_n))
    else $error("standard driver changed uncommanded");
  a_mode_clr: assert property (mode_wr |=> ##1 &(drive_oe_n |
    ~($past(mode_q, 2) & ~$past(hwdata[NCH-1:0], 2))))
    else $error("driver not released on return to standard");

  c_drive_write: cover property (drv_wr);
  c_pwm_toggle: cover property (mode_q != '0 && $fell(drive_oe_n[0]));
  c_ind_on: cover property (indicator != '0);
endmodule // rcip_top_sva

//--- verif/rcip_field.sv
// field side: relay sockets with pull-ups and input relays
`timescale 1ns/100ps
module rcip_field
  import rcip_pkg::*;
(
  // driver pins from the block
  input  wire logic [NUM_CH-1:0] drive_out_n,
  input  wire logic [NUM_CH-1:0] drive_oe_n,
  // field signals energising input relays
  input  wire logic [NUM_CH-1:0] ext_in,
  // sensed channel state
  output logic      [NUM_CH-1:0] chan_monitor
);
  logic [NUM_CH-1:0] pin;

  // a released pin floats up to the pull-up
  assign pin = drive_oe_n | drive_out_n;
  // either the driver or the input relay energises the channel
  assign chan_monitor = ~pin | ext_in;
endmodule // rcip_field

//--- verif/rcip_bench.sv
// self-checking bench for the relay channel block over ahb-lite
`timescale 1ns/100ps
module rcip_bench
  import rcip_pkg::*;
;
  localparam int U = 8;
  localparam int S = 40;
  localparam logic [15:0] EXT = 16'h8000;
  localparam logic [15:0] DRV = 16'h25c3;

  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [15:0] chan_monitor;
  logic [15:0] drive_out_n;
  logic [15:0] drive_oe_n;
  logic [15:0] indicator;
  logic [15:0] ext_in;
  logic [31:0] rv;
  int          lo;
  int          hi;
  int          n_fail;
  int          compares;

  rcip_top #(.UNIT_CYC(U), .SAMPLE_CYC_P(S)) DUT (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .chan_monitor(chan_monitor),
    .drive_out_n(drive_out_n), .drive_oe_n(drive_oe_n),
    .indicator(indicator));

  rcip_field u_field (.drive_out_n(drive_out_n), .drive_oe_n(drive_oe_n),
    .ext_in(ext_in), .chan_monitor(chan_monitor));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the slave never stalls, but still wait on hready rather than assume a cycle count
  task automatic edge_rdy;
    int j;
    j = 0;
    do begin
      @(posedge clk);
      j++;
    end while (hready !== 1'b1 && j < 64);
    if (hready !== 1'b1) begin
      n_fail++;
      test_done;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    edge_rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy;
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rv, exp);
  endtask

  // bounded run length of channel 0 driver at one level
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (drive_oe_n[0] === lvl && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      test_done;
    end
  endtask

  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_in = EXT;
    n_fail = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk({16'h0, drive_oe_n}, 32'h0000ffff);
    rd(OFS_DRIVE, 32'h0);
    rd(OFS_MODE, 32'h0);
    rd(OFS_PHYS, 32'h0);
    repeat (3 * S) @(posedge clk);
    rd(OFS_PHYS, {16'h0, EXT});
    // channel 15 holds an input relay, its driver bit stays clear
    wr(OFS_DRIVE, {16'h0, DRV});
    rd(OFS_DRIVE, {16'h0, DRV});
    rd(OFS_PHYS, {16'h0, EXT});
    chk({16'h0, drive_oe_n}, {16'h0, ~DRV});
    repeat (3 * S) @(posedge clk);
    rd(OFS_PHYS, {16'h0, DRV | EXT});
    chk({16'h0, indicator}, {16'h0, DRV | EXT});
    wr(OFS_MODE, 32'h00007ffe);
    rd(OFS_MODE, 32'h00007ffe);
    chk({16'h0, drive_oe_n}, 32'h0000fffe);
    wr(OFS_MODE, 32'h00000001);
    wr(OFS_PWM_SEL, 32'h0);
    rd(OFS_PWM_TIME, 32'h00000100);
    wr(OFS_PWM_TIME, 32'h00000002);
    rd(OFS_PWM_TIME, 32'h00000102);
    run_len(1'b0, lo);
    run_len(1'b1, lo);
    run_len(1'b0, lo);
    run_len(1'b1, hi);
    chk(lo, 2 * U);
    chk(hi, U);
    chk({16'h0, drive_oe_n[15:1], 1'b1}, 32'h0000ffff);
    wr(OFS_MODE, 32'h0);
    rd(OFS_DRIVE, 32'h0);
    chk({16'h0, drive_oe_n}, 32'h0000ffff);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    rd(OFS_MODE, 32'h0);
    // a second reset right after drive bits 0 and 1 are written, before the drivers turn on
    wr(OFS_DRIVE, 32'h00000003);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({16'h0, drive_oe_n}, 32'h0000ffff);
    rd(OFS_DRIVE, 32'h0);
    test_done;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done;
  end
endmodule // rcip_bench

bind rcip_top rcip_top_sva #(.NCH(NCH)) u_sva (.clk(clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .chan_monitor(chan_monitor),
  .drive_out_n(drive_out_n), .drive_oe_n(drive_oe_n),
  .indicator(indicator));
